// [pmh_top.sv]
// Summary of operation
// - four write, three read byte registers
// - data buffer behind one auto-incrementing address
// - idle holds bias or keeps extracting bits
// - bit seven restarts bit clock acquisition in receive mode, not with cancel
// - bit six restarts level acquisition in receive mode, not with cancel
// - non-null task code other than cancel starts a task, except code two in transmit mode
// - transmit task clears free, moves data
// - moved out sets free, flag, pin
// - receive task fills buffer then frees; sync search and pattern load only free
// - received bytes read from byte zero
// - head is seven bytes as listed
// - check byte nibbles cover control bytes
// - bytes go out msb first
// - block is data plus checksum bytes
// - head then zero to thirty-two blocks
// - task codes as in the table
`default_nettype none
module pmh_top import pmh_pkg::*; (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // host register port pins
  input  wire logic       cs_n_in,
  input  wire logic       wr_n_in,
  input  wire logic       rd_n_in,
  input  wire logic       reg_select_low_in,
  input  wire logic       reg_select_high_in,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe_out,
  output logic            interrupt_out_n_out,
  // receive path, same clock
  input  wire logic       rx_bit_in,
  input  wire logic       rx_bit_valid_in,
  input  wire logic [7:0] quality_in,
  // line and analog control
  output logic            tx_bit_out,
  output logic            tx_drive_out,
  output logic            bit_clock_acquire_out,
  output logic            level_acquire_out,
  output logic      [1:0] loop_bandwidth_setting_out,
  output logic      [1:0] level_response_setting_out
);
  logic [2:0]  strb_s;
  logic [9:0]  bus_s;
  logic        wr_act_d, rd_act_d;
  logic [1:0]  addr_hold;
  logic [7:0]  wdata_hold;
  logic [7:0]  mode, ctrl;
  logic        buffer_free, irq_flag, err_flag, moban;
  logic [7:0]  buf_mem [BUF_BYTES];
  logic [4:0]  ptr, idx, cnt_total, cnt_data;
  logic [2:0]  job, bitcnt;
  pmh_state_t  state;
  logic [18:0] rx_sh;
  logic [15:0] sync_pat, crc;
  logic        scram_run;
  logic [8:0]  lfsr;
  logic [7:0]  tx_sh;
  logic [2:0]  tx_left;
  logic [11:0] tick_cnt;
  logic        fifo_in_ready, fifo_out_valid;
  logic [7:0]  fifo_out_data;

  pmh_sync #(.W(3)) u_strb (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in({cs_n_in, wr_n_in, rd_n_in}), .q_out(strb_s));
  pmh_sync #(.W(10)) u_bus (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in({reg_select_high_in, reg_select_low_in, host_data_in}), .q_out(bus_s));

  // strobe decode: an access acts when its strobe ends
  wire        wr_act   = ~strb_s[2] & ~strb_s[1];
  wire        rd_act   = ~strb_s[2] & ~strb_s[0];
  wire        wr_done  = wr_act_d & ~wr_act;
  wire        rd_done  = rd_act_d & ~rd_act;
  wire        cmd_wr   = wr_done & (addr_hold == REG_CMD);
  wire [2:0]  task_in  = wdata_hold[2:0];
  wire        tx_mode  = mode[MODE_TX_BIT];
  wire        psave    = mode[MODE_PSAVE_BIT];
  wire        is_null  = (task_in == TASK_NULL);
  wire        is_cncl  = (task_in == TASK_CANCEL);
  wire        acq_ok   = cmd_wr & ~tx_mode & ~is_cncl;
  wire        tx_task  = cmd_wr & tx_mode & ~is_null & ~is_cncl & (task_in != TASK_R3H)
                         & (task_in != TASK_SPECL);
  wire        tso_task = cmd_wr & tx_mode & (task_in == TASK_SPECL);
  wire        rx_task  = cmd_wr & ~tx_mode & ~is_null & ~is_cncl;
  wire        buf_acc  = (addr_hold == REG_DATA) & (wr_done | rd_done);
  wire [4:0]  ptr_inc  = (ptr == PTR_LAST) ? PTR_ZERO : ptr + 5'h01;
  wire [7:0]  status   = {buffer_free, irq_flag, err_flag, moban, 4'h0};

  // transmit byte selection: data, then check byte or checksum
  wire [7:0]  fec_byte = {pmh_fec(buf_mem[IDX_CTRL0]), pmh_fec(buf_mem[IDX_CTRL1])};
  wire [7:0]  mv_byte  = (idx < cnt_data) ? buf_mem[idx] :
                         (job == TASK_HEAD) ? fec_byte :
                         (idx == IDX_CRC_HI) ? crc[15:8] : crc[7:0];
  wire        push     = (state == ST_MOVE) & fifo_in_ready;
  wire        mv_last  = push & (idx == cnt_total - 5'h01);

  // receive decode
  wire [18:0] nsh      = {rx_sh[17:0], rx_bit_in};
  wire        rx_bit   = rx_bit_valid_in & ~tx_mode;
  wire [4:0]  errs     = 5'($countones(nsh[15:0] ^ sync_pat));
  wire        sync_hit = rx_bit & (state == ST_HUNT) & (errs <= 5'h01);
  wire        byte_in  = rx_bit & (state == ST_COLLECT) & (bitcnt == BIT_IN_BYTE);
  wire        rx_last  = byte_in & (idx == cnt_total - 5'h01);
  wire        load_sync_pattern_job     = rx_task & (task_in == TASK_SPECL);
  wire        rx_fin   = rx_last | load_sync_pattern_job | (sync_hit & (job == TASK_QUAD));
  wire        hd_job   = (job == TASK_HEAD) | (job == TASK_R3H);

  // bit serialiser timing
  wire        tick     = (tick_cnt == '0);
  wire        line_on  = tx_mode & ~psave;
  wire        pop      = tick & line_on & (tx_left == '0);

  // register port capture
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_act_d   <= 1'b0;
      rd_act_d   <= 1'b0;
      addr_hold  <= REG_DATA;
      wdata_hold <= 8'h00;
    end
    else
    begin
      wr_act_d   <= wr_act;
      rd_act_d   <= rd_act;
      addr_hold  <= (wr_act | rd_act) ? bus_s[9:8] : addr_hold;
      wdata_hold <= wr_act ? bus_s[7:0] : wdata_hold;
    end
  end

  // write-only registers and read mux
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode             <= MODE_RESET;
      ctrl             <= CTRL_RESET;
      host_data_out    <= 8'h00;
      host_data_oe_out <= 1'b0;
    end
    else
    begin
      mode <= (wr_done & (addr_hold == REG_MODE)) ? wdata_hold : mode;
      ctrl <= (wr_done & (addr_hold == REG_CTRL)) ? wdata_hold : ctrl;
      host_data_oe_out <= rd_act;
      unique case (bus_s[9:8])
        REG_DATA: host_data_out <= buf_mem[ptr];
        REG_CMD:  host_data_out <= status;
        REG_CTRL: host_data_out <= quality_in;
        REG_MODE: host_data_out <= 8'h00;
      endcase
    end
  end

  // buffer storage: receive results first, host writes otherwise
  always_ff @(posedge clk_in)
  begin
    if (byte_in & (idx < cnt_data))
      buf_mem[idx] <= nsh[7:0];
    else if (buf_acc & wr_done)
      buf_mem[ptr] <= wdata_hold;
  end

  // status flags; hardware set wins over a read clear
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      buffer_free <= 1'b1;
      irq_flag    <= 1'b0;
      err_flag    <= 1'b0;
      moban       <= 1'b0;
      ptr         <= PTR_ZERO;
    end
    else
    begin
      if (mv_last | rx_fin)
        buffer_free <= 1'b1;
      else if (tx_task | rx_task)
        buffer_free <= 1'b0;
      else if (cmd_wr & is_cncl)
        buffer_free <= 1'b1;
      if (mv_last | rx_fin)
        irq_flag <= 1'b1;
      else if (rd_done & (addr_hold == REG_CMD))
        irq_flag <= 1'b0;
      if (rx_task)
        err_flag <= 1'b0;
      else if (rx_last & hd_job)
        err_flag <= (nsh[7:0] != {pmh_fec(buf_mem[PTR_ZERO]), pmh_fec(buf_mem[IDX_SYNC1])});
      if (sync_hit)
        moban <= (nsh[18] & nsh[17]) | (nsh[18] & nsh[16]) | (nsh[17] & nsh[16]);
      if (cmd_wr & ~is_null | rx_fin)
        ptr <= PTR_ZERO;
      else if (buf_acc)
        ptr <= ptr_inc;
    end
  end

  // task sequencer
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state     <= ST_IDLE;
      job       <= TASK_NULL;
      idx       <= PTR_ZERO;
      cnt_total <= PTR_ZERO;
      cnt_data  <= PTR_ZERO;
      bitcnt    <= '0;
      crc       <= CRC_SEED;
      sync_pat  <= SYNC_RESET;
    end
    else if (cmd_wr & is_cncl)
      state <= ST_IDLE;
    else if (tx_task)
    begin
      state <= ST_MOVE;
      job   <= task_in;
      idx   <= PTR_ZERO;
      crc   <= CRC_SEED;
      unique case (task_in)
        TASK_HEAD:  {cnt_total, cnt_data} <= {CNT_HEAD_TX, CNT_HEAD_DAT};
        TASK_BLOCK: {cnt_total, cnt_data} <= {CNT_BLK_TX, CNT_BLK_DAT};
        TASK_QUAD:  {cnt_total, cnt_data} <= {CNT_QUAD, CNT_QUAD};
        default:    {cnt_total, cnt_data} <= {CNT_ONE, CNT_ONE};
      endcase
    end
    else if (rx_task)
    begin
      job    <= task_in;
      idx    <= PTR_ZERO;
      bitcnt <= '0;
      unique case (task_in)
        TASK_HEAD, TASK_QUAD: state <= ST_HUNT;
        TASK_SPECL: state <= ST_IDLE;
        default:    state <= ST_COLLECT;
      endcase
      unique case (task_in)
        TASK_R3H:   {cnt_total, cnt_data} <= {CNT_HEAD_RX, CNT_HEAD_RX};
        TASK_BLOCK: {cnt_total, cnt_data} <= {CNT_BLK_DAT, CNT_BLK_DAT};
        TASK_HEAD:  {cnt_total, cnt_data} <= {CNT_HEAD_RX, CNT_KEEP_HD};
        default:    {cnt_total, cnt_data} <= {CNT_ONE, CNT_ONE};
      endcase
      if (load_sync_pattern_job)
        sync_pat <= {buf_mem[PTR_ZERO], buf_mem[IDX_SYNC1]};
    end
    else if (push)
    begin
      idx   <= idx + 5'h01;
      crc   <= (idx < cnt_data) ? pmh_crc(crc, mv_byte) : crc;
      state <= mv_last ? ST_IDLE : ST_MOVE;
    end
    else if (sync_hit)
    begin
      state  <= (job == TASK_QUAD) ? ST_IDLE : ST_COLLECT;
      bitcnt <= '0;
    end
    else if (rx_bit & (state == ST_COLLECT))
    begin
      bitcnt <= bitcnt + 3'h1;
      idx    <= byte_in ? idx + 5'h01 : idx;
      state  <= rx_last ? ST_IDLE : ST_COLLECT;
    end
  end

  // received bit history, kept running even when idle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rx_sh <= '0;
    else if (rx_bit)
      rx_sh <= nsh;
  end

  // acquisition restart pulses and control fields
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bit_clock_acquire_out      <= 1'b0;
      level_acquire_out          <= 1'b0;
      loop_bandwidth_setting_out <= 2'h0;
      level_response_setting_out <= 2'h0;
    end
    else
    begin
      bit_clock_acquire_out      <= acq_ok & wdata_hold[CMD_BC_BIT];
      level_acquire_out          <= acq_ok & wdata_hold[CMD_LV_BIT];
      loop_bandwidth_setting_out <= ctrl[CTRL_BW_LSB +: 2];
      level_response_setting_out <= ctrl[CTRL_LV_LSB +: 2];
    end
  end

  pmh_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (cmd_wr & is_cncl),
    .in_valid_in   (state == ST_MOVE),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (mv_byte),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (pop),
    .out_data_out  (fifo_out_data)
  );

  // serialiser: fifo bytes msb first, else scrambler, else bias
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt     <= BIT_LAST;
      tx_sh        <= 8'h00;
      tx_left      <= '0;
      scram_run    <= 1'b0;
      lfsr         <= SCR_SEED;
      tx_bit_out   <= 1'b0;
      tx_drive_out <= 1'b0;
      interrupt_out_n_out <= 1'b1;
    end
    else
    begin
      interrupt_out_n_out <= ~(irq_flag & mode[MODE_IRQEN_BIT]);
      tick_cnt <= tick ? BIT_LAST : tick_cnt - 12'h001;
      if (tso_task)
        scram_run <= 1'b1;
      else if ((pop & fifo_out_valid) | (cmd_wr & is_cncl))
        scram_run <= 1'b0;
      if (tick & ~line_on)
        tx_drive_out <= 1'b0;
      else if (tick & (tx_left != '0))
      begin
        tx_bit_out <= tx_sh[7];
        tx_sh      <= {tx_sh[6:0], 1'b0};
        tx_left    <= tx_left - 3'h1;
      end
      else if (pop & fifo_out_valid)
      begin
        tx_bit_out   <= fifo_out_data[7];
        tx_sh        <= {fifo_out_data[6:0], 1'b0};
        tx_left      <= BIT_IN_BYTE;
        tx_drive_out <= 1'b1;
      end
      else if (pop & scram_run)
      begin
        tx_bit_out   <= lfsr[0];
        lfsr         <= {lfsr[4] ^ lfsr[0], lfsr[8:1]};
        tx_drive_out <= 1'b1;
      end
      else if (pop)
        tx_drive_out <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rx_acq_write;
    cmd_wr & ~tx_mode & ~is_cncl;
  endsequence
  property p_bc_start;
    s_rx_acq_write ##0 wdata_hold[CMD_BC_BIT] |=> bit_clock_acquire_out;
  endproperty
  a_bc_start: assert property (p_bc_start) else $error("bit clock restart missed");
  property p_lv_start;
    s_rx_acq_write ##0 wdata_hold[CMD_LV_BIT] |=> level_acquire_out;
  endproperty
  a_lv_start: assert property (p_lv_start) else $error("level restart missed");
  property p_acq_tx;
    tx_mode & $stable(tx_mode) |=> !bit_clock_acquire_out && !level_acquire_out;
  endproperty
  a_acq_tx: assert property (p_acq_tx) else $error("acquisition in transmit");
  property p_tx_clear;
    tx_task |=> !buffer_free && state == ST_MOVE;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit task did not start");
  property p_tx_done;
    mv_last |=> buffer_free && irq_flag ##1 (interrupt_out_n_out == !mode[MODE_IRQEN_BIT]);
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("transmit end not flagged");
  property p_rx_done;
    rx_last |=> buffer_free && ptr == PTR_ZERO && state == ST_IDLE;
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive end not flagged");
  property p_ptr_step;
    buf_acc && !cmd_wr && !rx_fin |=> ptr == $past(ptr_inc);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("buffer pointer did not step");
  property p_bias;
    tick && !line_on |=> !tx_drive_out;
  endproperty
  a_bias: assert property (p_bias) else $error("line driven while idle");
  property p_msb;
    pop && fifo_out_valid |=> tx_bit_out == $past(fifo_out_data[7]) && tx_left == BIT_IN_BYTE;
  endproperty
  a_msb: assert property (p_msb) else $error("byte not sent msb first");
endmodule : pmh_top
`default_nettype wire

// [pmh_pkg.sv]
`default_nettype none
package pmh_pkg;
  // register selects on the two address pins
  localparam logic [1:0] REG_DATA = 2'h0;
  localparam logic [1:0] REG_CMD  = 2'h1;
  localparam logic [1:0] REG_CTRL = 2'h2;
  localparam logic [1:0] REG_MODE = 2'h3;
  // shared data buffer
  localparam int         BUF_BYTES = 18;
  localparam logic [4:0] PTR_LAST  = 5'h11;
  localparam logic [4:0] PTR_ZERO  = 5'h00;
  // command fields
  localparam int CMD_BC_BIT = 7;
  localparam int CMD_LV_BIT = 6;
  // task codes; 2, 4 and 6 mean different tasks in the two directions
  localparam logic [2:0] TASK_NULL   = 3'h0;
  localparam logic [2:0] TASK_HEAD   = 3'h1;
  localparam logic [2:0] TASK_R3H    = 3'h2;
  localparam logic [2:0] TASK_BLOCK  = 3'h3;
  localparam logic [2:0] TASK_QUAD   = 3'h4;
  localparam logic [2:0] TASK_SINGLE = 3'h5;
  localparam logic [2:0] TASK_SPECL  = 3'h6;
  localparam logic [2:0] TASK_CANCEL = 3'h7;
  // mode, status and control fields
  localparam int MODE_TX_BIT    = 0;
  localparam int MODE_IRQEN_BIT = 1;
  localparam int MODE_PSAVE_BIT = 2;
  localparam int ST_FREE_BIT    = 7;
  localparam int ST_IRQ_BIT     = 6;
  localparam int ST_ERR_BIT     = 5;
  localparam int ST_MOB_BIT     = 4;
  localparam int CTRL_BW_LSB    = 0;
  localparam int CTRL_LV_LSB    = 2;
  // byte counts of the tasks
  localparam logic [4:0] CNT_HEAD_TX  = 5'h07;
  localparam logic [4:0] CNT_HEAD_DAT = 5'h06;
  localparam logic [4:0] CNT_BLK_TX   = 5'h14;
  localparam logic [4:0] CNT_BLK_DAT  = 5'h12;
  localparam logic [4:0] CNT_QUAD     = 5'h04;
  localparam logic [4:0] CNT_ONE      = 5'h01;
  localparam logic [4:0] CNT_HEAD_RX  = 5'h03;
  localparam logic [4:0] CNT_KEEP_HD  = 5'h02;
  localparam logic [4:0] IDX_CTRL0    = 5'h04;
  localparam logic [4:0] IDX_CTRL1    = 5'h05;
  localparam logic [4:0] IDX_CRC_HI   = 5'h12;
  localparam logic [4:0] IDX_SYNC1    = 5'h01;
  // bit timing
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         BIT_PERIOD_NS = 125000;
  localparam int         BIT_CYCLES    = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] BIT_LAST     = 12'(BIT_CYCLES - 1);
  localparam logic [2:0] BIT_IN_BYTE   = 3'h7;
  // reset values
  localparam logic [15:0] SYNC_RESET = 16'h0000;
  localparam logic [15:0] CRC_SEED   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'h8005;
  localparam logic [8:0]  SCR_SEED   = 9'h1FF;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam int FIFO_W     = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_MOVE    = 2'b01,
    ST_HUNT    = 2'b10,
    ST_COLLECT = 2'b11
  } pmh_state_t;

  // four check bits of one control byte: two nibble parities, then odd and even bit parities
  function automatic logic [3:0] pmh_fec(input logic [7:0] b);
    pmh_fec = {^b[7:4], ^b[3:0], ^{b[7], b[5], b[3], b[1]}, ^{b[6], b[4], b[2], b[0]}};
  endfunction : pmh_fec

  // checksum update over one byte, msb first
  function automatic logic [15:0] pmh_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    pmh_crc = r;
  endfunction : pmh_crc
endpackage : pmh_pkg
`default_nettype wire

// [pmh_sync.sv]
`default_nettype none
module pmh_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // raw and synchronised levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  // two flops, the first read only by the second
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta  <= '1;
      q_out <= '1;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : pmh_sync
`default_nettype wire

// [pmh_fifo.sv]
`default_nettype none
module pmh_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // clock, reset and flush
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         flush_in,
  // filling side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // draining side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  // handshake decode, full and empty from the count
  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = mem[rd_ptr];

  // storage
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end

  // pointers and fill level
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (flush_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count  <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pmh_fifo
`default_nettype wire

// [pmh_host.sv]
`default_nettype none
// behavioural host: one register access at a time on the port pins
module pmh_host import pmh_pkg::*; (
  // clock
  input  wire logic       clk_in,
  // pins toward the device
  output logic            cs_n_out,
  output logic            wr_n_out,
  output logic            rd_n_out,
  output logic      [1:0] sel_out,
  output logic      [7:0] drv_out,
  // resolved data bus
  input  wire logic [7:0] bus_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle pins at time zero
  initial
  begin
    {cs_n_out, wr_n_out, rd_n_out} = 3'h7;
    sel_out = 2'h0;
    drv_out = 8'h00;
  end
  // write: strobes held five cycles, released data shows its inverse
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {cs_n_out, wr_n_out, sel_out, drv_out} = {2'b00, a, d};
    repeat (5) @(negedge clk_in);
    {cs_n_out, wr_n_out, drv_out} = {2'b11, ~d};
    repeat (6) @(negedge clk_in);
  endtask : wr
  // read: data taken while the strobe is still low
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk_in);
    {cs_n_out, rd_n_out, sel_out} = {2'b00, a};
    repeat (5) @(negedge clk_in);
    d = bus_in;
    {cs_n_out, rd_n_out} = 2'b11;
    repeat (6) @(negedge clk_in);
  endtask : rd
endmodule : pmh_host
`default_nettype wire

// [pmh_top_tb.sv]
`default_nettype none
module pmh_top_tb import pmh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // clock, reset and receive side stimulus
  logic       clk_in, rst_n_in, rx_bit, rx_vld;
  logic [7:0] quality;
  // host pins and device outputs
  logic       cs_n, wr_n, rd_n, oe, irq_n, txb, txd, bca, lva;
  logic [1:0] sel, bw, lr;
  logic [7:0] drv, dout, v;
  wire  logic [7:0] bus;
  int         bad_count, n_compared, bc_cnt, lv_cnt, k;
  // device drives the bus while its output enable is high
  assign bus = oe ? dout : drv;
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  pmh_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .wr_n_in(wr_n),
    .rd_n_in(rd_n), .reg_select_low_in(sel[0]), .reg_select_high_in(sel[1]),
    .host_data_in(bus), .host_data_out(dout), .host_data_oe_out(oe),
    .interrupt_out_n_out(irq_n), .rx_bit_in(rx_bit), .rx_bit_valid_in(rx_vld),
    .quality_in(quality), .tx_bit_out(txb), .tx_drive_out(txd),
    .bit_clock_acquire_out(bca), .level_acquire_out(lva),
    .loop_bandwidth_setting_out(bw), .level_response_setting_out(lr));
  pmh_host host (.clk_in(clk_in), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
    .sel_out(sel), .drv_out(drv), .bus_in(bus));
  // count acquisition pulses
  always @(negedge clk_in)
  begin
    if (bca === 1'b1) bc_cnt++;
    if (lva === 1'b1) lv_cnt++;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // wait for the interrupt pin, bounded
  task automatic wait_irq;
    for (k = 0; k < 9000 && irq_n !== 1'b0; k++) @(negedge clk_in);
  endtask : wait_irq
  // feed received bits msb first, one valid strobe every four cycles
  task automatic feed(input logic [31:0] b, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      rx_bit = b[i];
      rx_vld = 1'b1;
      @(negedge clk_in);
      rx_vld = 1'b0;
      repeat (3) @(negedge clk_in);
    end
  endtask : feed
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (90000) @(posedge clk_in);
    bad_count++;
    complete_run();
  end
  initial
  begin
    {rst_n_in, rx_bit, rx_vld} = 3'h0;
    {bad_count, n_compared, bc_cnt, lv_cnt} = '0;
    quality = 8'h5A;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    host.rd(REG_CMD, v);
    chk(v, 8'h80);
    host.rd(REG_MODE, v);
    chk(v, 8'h00);
    host.rd(REG_CTRL, v);
    chk(v, 8'h5A);
    host.wr(REG_CTRL, 8'h0E);
    chk({4'h0, lr, bw}, 8'h0E);
    host.wr(REG_MODE, 8'h02);
    host.wr(REG_CMD, 8'hC0);
    chk(8'(bc_cnt * 16 + lv_cnt), 8'h11);
    host.wr(REG_CMD, 8'h87);
    host.wr(REG_CMD, 8'h47);
    chk(8'(bc_cnt * 16 + lv_cnt), 8'h11);
    host.rd(REG_CMD, v);
    chk(v, 8'h80);
    // three-byte head read, bits fed after the task is written
    host.wr(REG_CMD, 8'h02);
    host.rd(REG_CMD, v);
    chk(v & 8'h80, 8'h00);
    feed(32'h00123456, 24);
    wait_irq();
    chk({7'h0, irq_n}, 8'h00);
    host.rd(REG_CMD, v);
    chk(v & 8'hC0, 8'hC0);
    chk({7'h0, irq_n}, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      host.rd(REG_DATA, v);
      chk(v, 8'(24'h123456 >> (16 - 8 * i)));
    end
    // sync pattern loaded through the buffer, acquisition, then a sync search
    host.wr(REG_CMD, 8'h07);
    host.wr(REG_DATA, 8'hA5);
    host.wr(REG_DATA, 8'h3C);
    host.wr(REG_CMD, 8'h06);
    host.rd(REG_CMD, v);
    chk(v, 8'hC0);
    host.wr(REG_CMD, 8'hC0);
    feed(32'h00000000, 12);
    host.wr(REG_CMD, 8'h04);
    feed(32'h0007A53C, 19);
    wait_irq();
    host.rd(REG_CMD, v);
    chk(v, 8'hD0);
    // transmit one byte
    host.wr(REG_MODE, 8'h03);
    chk({7'h0, txd}, 8'h00);
    host.wr(REG_CMD, 8'hC0);
    chk(8'(bc_cnt * 16 + lv_cnt), 8'h22);
    host.wr(REG_CMD, 8'h07);
    host.rd(REG_CMD, v);
    chk(v & 8'hC0, 8'h80);
    host.wr(REG_DATA, 8'hB4);
    host.wr(REG_CMD, 8'h05);
    wait_irq();
    chk({7'h0, irq_n}, 8'h00);
    host.rd(REG_CMD, v);
    chk(v & 8'hC0, 8'hC0);
    for (k = 0; k < 7000 && txd !== 1'b1; k++) @(negedge clk_in);
    repeat (1562) @(negedge clk_in);
    for (int i = 7; i >= 0; i--)
    begin
      chk({txd, 6'h0, txb}, {1'b1, 6'h0, 1'(8'hB4 >> i)});
      repeat (3125) @(negedge clk_in);
    end
    chk({7'h0, txd}, 8'h00);
    complete_run();
  end
endmodule : pmh_top_tb
`default_nettype wire
